/* File: rtl/asc_defs.vh */
/*
 * asc_defs.vh: register offsets, field positions, reset values and
 * timing counts of the conversion sequencer.
 * assumes: included by rtl/asc_top.v and the bench; word-addressed register port.
 */
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// register offsets (word index)
`define ASC_OFF_CTRL 4'h0
`define ASC_OFF_MODE 4'h1
`define ASC_OFF_CHAN 4'h2
`define ASC_OFF_SAMP 4'h3
`define ASC_OFF_STAT 4'h4
`define ASC_OFF_RES 4'h5
`define ASC_OFF_IRQ 4'h6
`define ASC_OFF_MASK 4'h7

// control bits
`define ASC_CTRL_START 0
`define ASC_CTRL_STOP 1
`define ASC_CTRL_ENABLE 2

// mode fields
`define ASC_MODE_TRIG_LO 0
`define ASC_MODE_TRIG_HI 1
`define ASC_MODE_SCAN 2
`define ASC_MODE_SEQ 3

// trigger encodings
`define ASC_TRIG_SW 2'h0
`define ASC_TRIG_HW_NOWAIT 2'h1
`define ASC_TRIG_HW_WAIT 2'h2

// last external channel code and the channel codes above the external range
`define ASC_CH_EXT_LAST 5'h0E
`define ASC_CH_TEMP 5'h10
`define ASC_CH_VREF 5'h11
`define ASC_CH_AMP0 5'h12
`define ASC_CH_AMP1 5'h13
`define ASC_CH_REFP 5'h14
`define ASC_CH_REFN 5'h15
`define ASC_CH_LAST 5'h15

// sampling in half conversion-clock cycles: 13.5 clk default
`define ASC_SAMP_RESET 8'h1B
// whole conversion least 31.5 clk, i.e. 63 half cycles
`define ASC_CONV_MIN_HALF 8'h3F
`define ASC_SCAN_COUNT 2'h3

// interrupt status bits
`define ASC_IRQ_END 0
`define ASC_IRQ_SCAN 1

`endif

/* File: rtl/asc_top.v */
/*
 * asc_top.v: control of the 12-bit conversion sequencer: trigger modes,
 * single and scan channel selection, one-shot and repeated conversion,
 * sampling time, result and interrupt registers.
 * assumes: the conversion core drives a 12-bit result with a one-cycle
 * done pulse on REF_CLK_IN; the hardware trigger arrives from a pin.
 */
`timescale 1ns/100ps
`include "asc_defs.vh"

// Notes on behaviour
// (RQ1) each result is a 12-bit value taken from the conversion core.
// (RQ2) channels 0 through 14 select the external analog inputs.
// (RQ3) in software trigger mode only a written start begins a run.
// (RQ4) in hardware no-wait mode a trigger edge starts at once, core powered.
// (RQ5) in hardware wait mode the core sleeps until a trigger powers it up.
// (RQ6) select mode converts only the programmed channel.
// (RQ7) scan mode converts four consecutive channels upward from the first.
// (RQ8) one-shot mode converts the set once per start, then idles.
// (RQ9) sequential mode repeats the set until software stops it.
// (RQ10) trigger, channel and operation modes are independent fields.
// (RQ11) sampling time is programmable, default 13.5 conversion clocks.
// (RQ12) each conversion takes at least 31.5 conversion clocks.
// (RQ13) reference voltage and temperature sensor are selectable inputs.
// (RQ14) both gain amplifier outputs are selectable inputs.
// (RQ15) self-test may convert both references, inputs, sensor and reference.
// (RQ16) each result is stored readable and raises a conversion-end event.
// (RQ17) software changes settings only while conversion is stopped; the code accepts mode, channel and sampling writes at any time.
module asc_top
#(
    parameter RES_W = 12,
    parameter PWRUP_CYCLES = 8'h10
)
(
    input wire REF_CLK_IN,
    input wire ARST_N_IN,
    input wire [3:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RDATA_OUT,
    input wire HW_TRIG_IN,
    input wire CORE_DONE_IN,
    input wire [11:0] CORE_RESULT_IN,
    output reg CORE_POWER_OUT,
    output reg CORE_SAMPLE_OUT,
    output reg CORE_START_OUT,
    output reg [4:0] CORE_CHAN_OUT,
    output reg IRQ_OUT
);

    localparam ST_IDLE = 5'b00001;
    localparam ST_PWRUP = 5'b00010;
    localparam ST_SAMP = 5'b00100;
    localparam ST_CONV = 5'b01000;
    localparam ST_NEXT = 5'b10000;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg enable_reg;
    reg [1:0] trig_mode_reg;
    reg scan_reg;
    reg seq_reg;
    reg [4:0] chan_reg;
    reg [7:0] samp_reg;
    reg [11:0] result_reg;
    reg [4:0] result_chan_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg [7:0] count_reg;
    reg [7:0] count_next;
    reg [1:0] scan_idx_reg;
    reg [1:0] scan_idx_next;
    reg trig_s1_reg;
    reg trig_s2_reg;
    reg trig_s3_reg;
    reg stop_pend_reg;
    reg done_pulse;
    reg scan_done_pulse;
    reg [4:0] cur_chan;
    reg [4:0] next_chan;

    wire wr_ctrl = WR_IN && (ADDR_IN == `ASC_OFF_CTRL);
    wire sw_start = wr_ctrl && WDATA_IN[`ASC_CTRL_START];
    wire sw_stop = wr_ctrl && WDATA_IN[`ASC_CTRL_STOP];
    wire trig_edge = trig_s2_reg && !trig_s3_reg;
    wire hw_mode = (trig_mode_reg != `ASC_TRIG_SW);
    // a start is either a software write or a trigger edge, never both kinds
    wire go = enable_reg && (hw_mode ? trig_edge : sw_start); // see (RQ3) see (RQ4)
    // conversion phase length: pad so sampling plus conversion reach 31.5 clk
    wire [7:0] conv_half = (samp_reg >= `ASC_CONV_MIN_HALF) ? 8'h01 :
        (`ASC_CONV_MIN_HALF - samp_reg); // see (RQ12)
    wire last_in_set = !scan_reg || (scan_idx_reg == `ASC_SCAN_COUNT);

    // hardware trigger from a pin, two flops then an edge detector
    always @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
        end
        else
        begin
            trig_s1_reg <= HW_TRIG_IN;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
        end
    end

    // channel of the current conversion; scan steps upward from the base
    // the output follows the next index, so it is already steady when sampling starts
    always @*
    begin
        cur_chan = chan_reg + {3'b000, scan_idx_reg}; // see (RQ7)
        next_chan = chan_reg + {3'b000, scan_idx_next};
        if (!scan_reg)
        begin
            cur_chan = chan_reg; // see (RQ6)
            next_chan = chan_reg;
        end
    end

    // sequencer
    always @*
    begin
        state_next = state_reg;
        count_next = count_reg;
        scan_idx_next = scan_idx_reg;
        done_pulse = 1'b0;
        scan_done_pulse = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                scan_idx_next = 2'b00;
                if (go)
                begin
                    if (trig_mode_reg == `ASC_TRIG_HW_WAIT)
                    begin
                        state_next = ST_PWRUP; // see (RQ5)
                        count_next = PWRUP_CYCLES;
                    end
                    else
                    begin
                        state_next = ST_SAMP;
                        count_next = samp_reg; // see (RQ11)
                    end
                end
            end
            ST_PWRUP:
            begin
                count_next = count_reg - 8'h01;
                if (count_reg <= 8'h01)
                begin
                    state_next = ST_SAMP;
                    count_next = samp_reg;
                end
            end
            ST_SAMP:
            begin
                count_next = count_reg - 8'h01;
                if (count_reg <= 8'h01)
                begin
                    state_next = ST_CONV;
                    count_next = conv_half;
                end
            end
            ST_CONV:
            begin
                if (count_reg > 8'h00)
                begin
                    count_next = count_reg - 8'h01;
                end
                // the result is only accepted once the least time has run out
                if (count_reg <= 8'h01 && CORE_DONE_IN)
                begin
                    done_pulse = 1'b1; // see (RQ16)
                    state_next = ST_NEXT;
                end
            end
            ST_NEXT:
            begin
                count_next = samp_reg;
                if (last_in_set)
                begin
                    scan_done_pulse = scan_reg;
                    scan_idx_next = 2'b00;
                    if (seq_reg && !stop_pend_reg && enable_reg)
                    begin
                        state_next = ST_SAMP; // see (RQ9)
                    end
                    else
                    begin
                        state_next = ST_IDLE; // see (RQ8)
                    end
                end
                else if (stop_pend_reg)
                begin
                    state_next = ST_IDLE;
                end
                else
                begin
                    scan_idx_next = scan_idx_reg + 2'b01;
                    state_next = ST_SAMP;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // one sticky bit per event; the set wins over a write-one-to-clear in the same cycle
    wire [1:0] irq_set;
    wire irq_clr_wr = WR_IN && (ADDR_IN == `ASC_OFF_IRQ);
    genvar g;

    assign irq_set[`ASC_IRQ_END] = done_pulse;
    assign irq_set[`ASC_IRQ_SCAN] = scan_done_pulse;

    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_irq
            always @(posedge REF_CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                begin
                    irq_stat_reg[g] <= 1'b0;
                end
                else
                begin
                    irq_stat_reg[g] <= irq_set[g] ||
                        (irq_stat_reg[g] && !(irq_clr_wr && WDATA_IN[g])); // see (RQ16)
                end
            end
        end
    endgenerate

    always @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
            scan_idx_reg <= 2'b00;
            enable_reg <= 1'b0;
            trig_mode_reg <= `ASC_TRIG_SW;
            scan_reg <= 1'b0;
            seq_reg <= 1'b0;
            chan_reg <= 5'h00;
            samp_reg <= `ASC_SAMP_RESET;
            result_reg <= 12'h000;
            result_chan_reg <= 5'h00;
            irq_mask_reg <= 2'b00;
            stop_pend_reg <= 1'b0;
            RDATA_OUT <= 32'h0000_0000;
            CORE_POWER_OUT <= 1'b0;
            CORE_SAMPLE_OUT <= 1'b0;
            CORE_START_OUT <= 1'b0;
            CORE_CHAN_OUT <= 5'h00;
            IRQ_OUT <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            scan_idx_reg <= scan_idx_next;
            // stop held until the run ends, so a stop during a set is not lost
            if (sw_stop && state_reg != ST_IDLE)
            begin
                stop_pend_reg <= 1'b1; // see (RQ9)
            end
            else if (state_reg == ST_IDLE || state_next == ST_IDLE)
            begin
                stop_pend_reg <= 1'b0;
            end
            if (WR_IN)
            begin
                case (ADDR_IN)
                    `ASC_OFF_CTRL:
                    begin
                        enable_reg <= WDATA_IN[`ASC_CTRL_ENABLE];
                    end
                    `ASC_OFF_MODE:
                    begin
                        // fields are independent; no combination is refused
                        trig_mode_reg <= WDATA_IN[`ASC_MODE_TRIG_HI:`ASC_MODE_TRIG_LO]; // see (RQ10)
                        scan_reg <= WDATA_IN[`ASC_MODE_SCAN];
                        seq_reg <= WDATA_IN[`ASC_MODE_SEQ];
                    end
                    `ASC_OFF_CHAN:
                    begin
                        // codes past the last internal input are ignored; the channel keeps its value
                        if (WDATA_IN[4:0] <= `ASC_CH_LAST) // see (RQ13) see (RQ14) see (RQ15)
                        begin
                            chan_reg <= WDATA_IN[4:0]; // see (RQ2)
                        end
                    end
                    `ASC_OFF_SAMP:
                    begin
                        samp_reg <= WDATA_IN[7:0]; // see (RQ11)
                    end
                    `ASC_OFF_MASK:
                    begin
                        irq_mask_reg <= WDATA_IN[1:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
            if (done_pulse)
            begin
                result_reg <= CORE_RESULT_IN[RES_W-1:0]; // see (RQ1) see (RQ16)
                result_chan_reg <= cur_chan;
            end
            IRQ_OUT <= |(irq_stat_reg & irq_mask_reg);
            // wait mode keeps the core unpowered between triggers
            if (trig_mode_reg == `ASC_TRIG_HW_WAIT)
            begin
                CORE_POWER_OUT <= (state_next != ST_IDLE); // see (RQ5)
            end
            else
            begin
                // a set already running keeps power, so a disable cannot cut a conversion
                CORE_POWER_OUT <= enable_reg || (state_next != ST_IDLE); // see (RQ4)
            end
            CORE_SAMPLE_OUT <= (state_next == ST_SAMP);
            CORE_START_OUT <= (state_reg == ST_SAMP) && (state_next == ST_CONV);
            CORE_CHAN_OUT <= next_chan;
            RDATA_OUT <= 32'h0000_0000;
            if (RD_IN)
            begin
                case (ADDR_IN)
                    `ASC_OFF_CTRL:
                    begin
                        RDATA_OUT <= {29'h0, enable_reg, 2'b00};
                    end
                    `ASC_OFF_MODE:
                    begin
                        RDATA_OUT <= {28'h0, seq_reg, scan_reg, trig_mode_reg};
                    end
                    `ASC_OFF_CHAN:
                    begin
                        RDATA_OUT <= {27'h0, chan_reg};
                    end
                    `ASC_OFF_SAMP:
                    begin
                        RDATA_OUT <= {24'h0, samp_reg};
                    end
                    `ASC_OFF_STAT:
                    begin
                        RDATA_OUT <= {24'h0, scan_idx_reg, stop_pend_reg, state_reg};
                    end
                    `ASC_OFF_RES:
                    begin
                        RDATA_OUT <= {11'h0, result_chan_reg, 4'h0, result_reg};
                    end
                    `ASC_OFF_IRQ:
                    begin
                        RDATA_OUT <= {30'h0, irq_stat_reg};
                    end
                    `ASC_OFF_MASK:
                    begin
                        RDATA_OUT <= {30'h0, irq_mask_reg};
                    end
                    default:
                    begin
                        RDATA_OUT <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

endmodule

/* File: tb/asc_chk.sv */
/* asc_chk.sv: port assertions for asc_top, bound at the foot.
   assumes: one clock, asynchronous active-low reset. */
`timescale 1ns/100ps
module asc_chk (
    input wire REF_CLK_IN,
    input wire ARST_N_IN,
    input wire WR_IN,
    input wire RD_IN,
    input wire [31:0] RDATA_OUT,
    input wire HW_TRIG_IN,
    input wire CORE_DONE_IN,
    input wire CORE_POWER_OUT,
    input wire CORE_SAMPLE_OUT,
    input wire CORE_START_OUT,
    input wire [4:0] CORE_CHAN_OUT,
    input wire IRQ_OUT
);
default clocking dc @(posedge REF_CLK_IN);
endclocking
default disable iff (!ARST_N_IN);
reg [7:0] gap_reg;
reg [3:0] cause_reg;
// saturating, so a long idle never wraps into a false short gap
always @(posedge REF_CLK_IN or negedge ARST_N_IN)
begin
    if (!ARST_N_IN)
    begin
        gap_reg <= 8'hFF;
        cause_reg <= 4'hF;
    end
    else
    begin
        if (CORE_START_OUT)
            gap_reg <= 8'h00;
        else if (gap_reg != 8'hFF)
            gap_reg <= gap_reg + 8'h01;
        if (WR_IN || HW_TRIG_IN)
            cause_reg <= 4'h0;
        else if (cause_reg != 4'hF)
            cause_reg <= cause_reg + 4'h1;
    end
end
a_read_data_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
a_start_one_pulse: assert property (CORE_START_OUT |=> !CORE_START_OUT)
    else $error("start longer than one cycle");
a_sample_powered: assert property (CORE_SAMPLE_OUT || CORE_START_OUT |-> CORE_POWER_OUT)
    else $error("core active while unpowered");
a_start_ends_sample: assert property (CORE_START_OUT |-> $past(CORE_SAMPLE_OUT))
    else $error("start without sampling");
a_chan_held: assert property (CORE_SAMPLE_OUT && $past(CORE_SAMPLE_OUT) |-> $stable(CORE_CHAN_OUT))
    else $error("channel moved while sampling");
a_conv_min_len: assert property (CORE_START_OUT |-> gap_reg >= 8'h3E)
    else $error("conversions closer than minimum");
a_power_has_cause: assert property ($rose(CORE_POWER_OUT) |-> cause_reg <= 4'h8)
    else $error("power up without write or trigger");
a_irq_has_cause: assert property ($rose(IRQ_OUT) |-> $past(CORE_DONE_IN, 2) || $past(CORE_DONE_IN, 3)
    || $past(WR_IN) || $past(WR_IN, 2) || $past(WR_IN, 3))
    else $error("interrupt without cause");
endmodule
bind asc_top asc_chk i_asc_chk (.REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .WR_IN(WR_IN),
    .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .HW_TRIG_IN(HW_TRIG_IN), .CORE_DONE_IN(CORE_DONE_IN),
    .CORE_POWER_OUT(CORE_POWER_OUT), .CORE_SAMPLE_OUT(CORE_SAMPLE_OUT),
    .CORE_START_OUT(CORE_START_OUT), .CORE_CHAN_OUT(CORE_CHAN_OUT), .IRQ_OUT(IRQ_OUT));

/* File: tb/asc_core_mdl.sv */
/* asc_core_mdl.sv: behavioural conversion core.
   assumes: start pulse and channel from asc_top; delay set by the bench. */
`timescale 1ns/100ps
module asc_core_mdl (
    input wire clk_in,
    input wire arst_n_in,
    input wire start_in,
    input wire [4:0] chan_in,
    input wire [7:0] dly_in,
    output reg done_out,
    output reg [11:0] result_out
);
reg [7:0] cnt_reg;
reg [4:0] ch_reg;
always @(posedge clk_in or negedge arst_n_in)
begin
    if (!arst_n_in)
    begin
        cnt_reg <= 8'h00;
        ch_reg <= 5'h00;
        done_out <= 1'b0;
        result_out <= 12'h000;
    end
    else
    begin
        done_out <= 1'b0;
        // toggles outside done, so a sample an odd number of cycles late never matches
        result_out <= ~result_out;
        if (start_in)
        begin
            cnt_reg <= dly_in;
            ch_reg <= chan_in;
        end
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
        if (!start_in && cnt_reg == 8'h01)
        begin
            done_out <= 1'b1;
            result_out <= {ch_reg, 7'h35};
        end
    end
end
endmodule

/* File: tb/tb_adc_sequencer_control.sv */
/* tb_adc_sequencer_control.sv: self-checking bench for asc_top.
   assumes: asc_defs.vh on the include path, core model and checker. */
`timescale 1ns/100ps
`include "asc_defs.vh"
module tb_adc_sequencer_control;
reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, trig = 1'b0;
reg [3:0] adr = 4'h0;
reg [31:0] wd = 32'h0000_0000, lf = 32'hdcbf_fa49, got;
reg [7:0] dly = 8'h40, samp = 8'h1B, scnt = 8'h00, swid = 8'h00;
reg [4:0] c;
reg sc_end = 1'b0;
integer failures = 0, compares = 0, i, k, w;
wire [31:0] rdat;
wire [11:0] res;
wire [4:0] ch;
wire done, pwr, smp, st, irq;
always #20 clk = ~clk;
asc_top i_asc_top (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(adr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .HW_TRIG_IN(trig), .CORE_DONE_IN(done),
    .CORE_RESULT_IN(res), .CORE_POWER_OUT(pwr), .CORE_SAMPLE_OUT(smp),
    .CORE_START_OUT(st), .CORE_CHAN_OUT(ch), .IRQ_OUT(irq));
asc_core_mdl i_asc_core_mdl (.clk_in(clk), .arst_n_in(rst_n), .start_in(st), .chan_in(ch),
    .dly_in(dly), .done_out(done), .result_out(res));
// last sampling width
always @(posedge clk)
    if (smp)
        scnt <= scnt + 8'h01;
    else if (scnt != 8'h00)
    begin
        swid <= scnt;
        scnt <= 8'h00;
    end
function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function [31:0] exp_res(input [4:0] e);
    exp_res = {11'h000, e, 4'h0, e, 7'h35};
endfunction
task tally_and_finish;
begin
    if (failures == 0 && compares > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask
task cmp(input [31:0] e, input [31:0] g);
begin
    compares = compares + 1;
    if (g !== e)
    begin
        failures = failures + 1;
        $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
end
endtask
task wrr(input [3:0] a, input [31:0] d);
begin
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
end
endtask
task rdr(input [3:0] a);
begin
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdat;
    @(posedge clk);
end
endtask
task wt(input e);
begin
    w = 0;
    while (done !== 1'b1 && w < 3000)
    begin
        @(posedge clk);
        w = w + 1;
    end
    if (w >= 3000)
    begin
        failures = failures + 1;
        tally_and_finish;
    end
    repeat (3) @(posedge clk);
    cmp(32'(e), 32'(irq));
end
endtask
task rres(input [4:0] e);
begin
    wt(1'b1);
    rdr(`ASC_OFF_RES);
    cmp(exp_res(e), got);
    cmp({24'h0, samp}, {24'h0, swid});
    rdr(`ASC_OFF_IRQ);
    cmp({30'h0, sc_end, 1'b1}, got);
    wrr(`ASC_OFF_IRQ, 32'h0000_0003);
end
endtask
task setd;
begin
    lf = nxt(lf);
    // slow answers now and then
    dly <= 8'h41 - samp + {5'h0, lf[2:0]} + (lf[3] ? 8'h28 : 8'h00);
end
endtask
task idle;
begin
    w = 0;
    got = 32'h0000_0000;
    while (got[4:0] !== 5'h01 && w < 300)
    begin
        rdr(`ASC_OFF_STAT);
        w = w + 1;
    end
    cmp(32'h0000_0001, {27'h0, got[4:0]});
    if (got[4:0] !== 5'h01)
        tally_and_finish;
end
endtask
task trg;
begin
    setd;
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    trig <= 1'b0;
end
endtask
initial
begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdr(`ASC_OFF_SAMP);
    cmp(32'h0000_001B, got);
    rdr(4'h8);
    cmp(32'h0000_0000, got);
    wrr(`ASC_OFF_MASK, 32'h0000_0003);
    wrr(`ASC_OFF_CTRL, 32'h0000_0004);
    rdr(`ASC_OFF_STAT);
    cmp(32'h0000_0001, {27'h0, got[4:0]});
    for (i = 0; i < 8; i = i + 1)
    begin
        lf = nxt(lf);
        c = (i == 0) ? 5'(lf % 15) : ((i == 7) ? 5'h0E : 5'(i + 15));
        wrr(`ASC_OFF_CHAN, {27'h0, c});
        setd;
        wrr(`ASC_OFF_CTRL, 32'h0000_0005);
        rres(c);
        rdr(`ASC_OFF_STAT);
        cmp(32'h0000_0001, {27'h0, got[4:0]});
    end
    wrr(`ASC_OFF_CHAN, 32'h0000_0016);
    rdr(`ASC_OFF_CHAN);
    cmp(32'h0000_000E, got);
    wrr(`ASC_OFF_MASK, 32'h0000_0000);
    wrr(`ASC_OFF_CTRL, 32'h0000_0005);
    wt(1'b0);
    rdr(`ASC_OFF_IRQ);
    cmp(32'h0000_0001, got);
    wrr(`ASC_OFF_IRQ, 32'h0000_0001);
    rdr(`ASC_OFF_IRQ);
    cmp(32'h0000_0000, got);
    wrr(`ASC_OFF_MASK, 32'h0000_0003);
    // settings change only while stopped
    lf = nxt(lf);
    samp = 8'h04 + 8'(lf % 40);
    wrr(`ASC_OFF_SAMP, {24'h0, samp});
    c = 5'(lf[7:4] % 12);
    wrr(`ASC_OFF_CHAN, {27'h0, c});
    wrr(`ASC_OFF_MODE, 32'h0000_0004);
    setd;
    wrr(`ASC_OFF_CTRL, 32'h0000_0005);
    for (k = 0; k < 4; k = k + 1)
    begin
        sc_end = (k == 3);
        rres(5'(c + k));
    end
    sc_end = 1'b0;
    idle;
    wrr(`ASC_OFF_MODE, 32'h0000_0008);
    wrr(`ASC_OFF_CTRL, 32'h0000_0005);
    rres(c);
    rres(c);
    wrr(`ASC_OFF_CTRL, 32'h0000_0002);
    idle;
    wrr(`ASC_OFF_IRQ, 32'h0000_0003);
    wrr(`ASC_OFF_MODE, 32'h0000_0001);
    wrr(`ASC_OFF_CTRL, 32'h0000_0004);
    repeat (3) @(posedge clk);
    cmp(32'h0000_0001, 32'(pwr));
    rdr(`ASC_OFF_STAT);
    cmp(32'h0000_0001, {27'h0, got[4:0]});
    trg;
    rres(c);
    wrr(`ASC_OFF_CTRL, 32'h0000_0000);
    wrr(`ASC_OFF_MODE, 32'h0000_0006);
    wrr(`ASC_OFF_CTRL, 32'h0000_0004);
    repeat (3) @(posedge clk);
    cmp(32'h0000_0000, 32'(pwr));
    trg;
    for (k = 0; k < 4; k = k + 1)
    begin
        sc_end = (k == 3);
        rres(5'(c + k));
    end
    sc_end = 1'b0;
    idle;
    tally_and_finish;
end
endmodule
